// ==== core/ttl_pkg.sv ====
// Constants and types shared by the tape time locate control files
package ttl_pkg;

	localparam int TIME_W = 14;
	localparam int MEM_DEPTH = 9;
	localparam int MEM_AW = 4;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_KEY = 8'h08;
	localparam logic [7:0] ADDR_LOC = 8'h0c;
	localparam logic [7:0] ADDR_TAPE = 8'h10;
	localparam logic [7:0] ADDR_STAT = 8'h14;

	// Control register fields and reset value
	localparam int CTRL_SENSE = 0;
	localparam int CTRL_RANGE = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;

	// Command register bits (write one to issue)
	localparam int CMD_STOP = 0;
	localparam int CMD_REW = 1;
	localparam int CMD_FWD = 2;
	localparam int CMD_PLAY = 3;
	localparam int CMD_REC = 4;
	localparam int CMD_LOC = 5;
	localparam int CMD_TAPE_RST = 6;
	localparam int CMD_TO_TAPE = 7;
	localparam int CMD_TO_LOC = 8;
	localparam int CMD_LOC_RST = 9;
	localparam int CMD_W = 10;

	// Transport pin group order: {runout, play, forward, rewind, stop}
	localparam int EXT_W = 5;
	localparam int EXT_RUNOUT = 4;

	// Key codes
	localparam logic [3:0] KEY_ZERO = 4'h0;
	localparam logic [3:0] KEY_NINE = 4'h9;
	localparam logic [3:0] KEY_STORE = 4'ha;
	localparam logic [3:0] KEY_RECALL = 4'hb;

	typedef enum logic [5:0] {
		TTL_IDLE  = 6'b000001,
		TTL_PLAY  = 6'b000010,
		TTL_FWD   = 6'b000100,
		TTL_REW   = 6'b001000,
		TTL_LFAST = 6'b010000,
		TTL_LSLOW = 6'b100000
	} ttl_state_t;

	typedef enum logic [2:0] {
		TTL_KEY_NONE   = 3'b001,
		TTL_KEY_STORE  = 3'b010,
		TTL_KEY_RECALL = 3'b100
	} ttl_key_t;

endpackage : ttl_pkg

// ==== core/ttl_mem.sv ====
// Locate time memory with registered read data
`timescale 1ns/1ps
module ttl_mem #(
	parameter int DW    = 14,
	parameter int DEPTH = 9,
	parameter int AW    = 4
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [DW-1:0] wdata_i,
	output logic      [DW-1:0] rdata_o
);

	typedef struct packed {
		logic [DEPTH-1:0][DW-1:0] mem;
		logic [DW-1:0]            rdata;
	} ttl_mem_t;

	ttl_mem_t r;
	ttl_mem_t next_r;

	always_comb
	begin
		next_r = r;
		if (addr_i < AW'(DEPTH))
		begin
			next_r.rdata = r.mem[addr_i];
			if (we_i)
				next_r.mem[addr_i] = wdata_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			r <= '0;
		else
			r <= next_r;
	end

	assign rdata_o = r.rdata;

endmodule : ttl_mem

// ==== core/ttl_ctrl.sv ====
// Tape time locate control: counter, locate sequencer, memory keys, Wishbone slave
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
// What this block does
// - While difference display is on, every memory address key except recall is ignored.
// - Recall during difference display ends it and shows the locate time held before.
// - A locate command drives the transport at high speed toward the target time.
// - The locate slows near the target and stops within one count of it.
// - The tape time counts up in forward motion and down in rewind.
// - The count sense switch inverts the relation of sensed direction to counting.
// - The speed range setting scales the count, so a mismatch gives a two to one error.
// - A locate ends once tape time is within one count of locate time.
// - Difference display shows the absolute difference of locate time and tape time.
// - Stop, rewind, fast forward or tape runout cancels a locate in progress.
// - Play during a locate is held until it completes, and record is disabled meanwhile.
module ttl_ctrl #(
	parameter int SLOW_ZONE = 16
) (
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic [7:0]                    wb_adr_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic      [31:0]                   wb_dat_o,
	input  wire logic                          wb_we_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_cyc_i,
	output logic                               wb_ack_o,
	input  wire logic                          tape_pulse_i,
	input  wire logic                          tape_dir_i,
	input  wire logic [ttl_pkg::EXT_W-1:0]     machine_cmd_i,
	output logic                               drive_fwd_o,
	output logic                               drive_rew_o,
	output logic                               drive_slow_o,
	output logic                               play_o,
	output logic                               record_o
);

	localparam int TW = ttl_pkg::TIME_W;

	typedef struct packed {
		ttl_pkg::ttl_state_t        state;
		ttl_pkg::ttl_key_t          keymode;
		logic                       sense;
		logic                       range;
		logic [TW-1:0]              locate;
		logic [TW-1:0]              tape;
		logic                       prescale;
		logic                       diff_mode;
		logic                       play_pend;
		logic                       rec;
		logic                       mem_we;
		logic [ttl_pkg::MEM_AW-1:0] mem_addr;
		logic [1:0]                 mem_load;
		logic                       ack;
		logic [31:0]                dat;
		logic                       dir_m;
		logic                       dir_s;
		logic                       pulse_m;
		logic                       pulse_s;
		logic                       pulse_q;
		logic [ttl_pkg::EXT_W-1:0]  ext_m;
		logic [ttl_pkg::EXT_W-1:0]  ext_s;
		logic [ttl_pkg::EXT_W-1:0]  ext_q;
		logic [4:0]                 drv;
		logic [2:0]                 armed;
	} ttl_regs_t;

	ttl_regs_t r;
	ttl_regs_t next_r;

	logic                        bus_req;
	logic                        bus_wr;
	logic [31:0]                 wmask;
	logic [31:0]                 wdat;
	logic [ttl_pkg::EXT_W-1:0]   ext_rise;
	logic [ttl_pkg::CMD_W-1:0]   cmd;
	logic [TW:0]                 delta;
	logic [TW:0]                 absd;
	logic                        near_tgt;
	logic                        in_slow;
	logic                        count_up;
	logic                        pulse_edge;
	logic [3:0]                  key_code;
	logic                        key_wr;
	logic                        key_digit;
	logic [TW-1:0]               mem_rdata;

	assign bus_req = wb_cyc_i & wb_stb_i & ~r.ack;
	assign bus_wr = bus_req & wb_we_i;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdat = wb_dat_i & wmask;
	// Edges count only once the synchronisers hold real pin levels, so a pin high at reset is no edge
	assign ext_rise = r.armed[2] ? (r.ext_s & ~r.ext_q) : '0;

	// Software commands and front panel rising edges share one command word
	always_comb
	begin
		cmd = '0;
		if (bus_wr && wb_adr_i == ttl_pkg::ADDR_CMD)
			cmd = wdat[ttl_pkg::CMD_W-1:0];
		cmd[ttl_pkg::CMD_STOP] = cmd[ttl_pkg::CMD_STOP] | ext_rise[0];
		cmd[ttl_pkg::CMD_REW] = cmd[ttl_pkg::CMD_REW] | ext_rise[1];
		cmd[ttl_pkg::CMD_FWD] = cmd[ttl_pkg::CMD_FWD] | ext_rise[2];
		cmd[ttl_pkg::CMD_PLAY] = cmd[ttl_pkg::CMD_PLAY] | ext_rise[3];
	end

	assign delta = {1'b0, r.locate} - {1'b0, r.tape};
	assign absd = delta[TW] ? (~delta + (TW+1)'(1)) : delta;
	assign near_tgt = absd <= (TW+1)'(1);
	assign in_slow = absd <= (TW+1)'(SLOW_ZONE);
	assign count_up = r.dir_s ^ r.sense;
	assign pulse_edge = r.armed[2] & r.pulse_s & ~r.pulse_q;
	assign key_wr = bus_wr && wb_adr_i == ttl_pkg::ADDR_KEY;
	assign key_code = wdat[3:0];
	assign key_digit = key_code != ttl_pkg::KEY_ZERO && key_code <= ttl_pkg::KEY_NINE;

	always_comb
	begin
		next_r = r;
		next_r.ack = bus_req;
		next_r.dir_m = tape_dir_i;
		next_r.dir_s = r.dir_m;
		next_r.pulse_m = tape_pulse_i;
		next_r.pulse_s = r.pulse_m;
		next_r.pulse_q = r.pulse_s;
		next_r.ext_m = machine_cmd_i;
		next_r.ext_s = r.ext_m;
		next_r.ext_q = r.ext_s;
		next_r.armed = {r.armed[1:0], 1'b1};
		next_r.mem_we = 1'b0;
		next_r.mem_load = {r.mem_load[0], 1'b0};

		// Tape time counter, halved in the upper speed range
		if (pulse_edge)
		begin
			next_r.prescale = r.range ? ~r.prescale : 1'b0;
			if (!r.range || r.prescale)
				next_r.tape = count_up ? r.tape + TW'(1) : r.tape - TW'(1);
		end
		if (cmd[ttl_pkg::CMD_TAPE_RST])
			next_r.tape = '0;
		else if (cmd[ttl_pkg::CMD_TO_TAPE])
			next_r.tape = r.locate;

		if (bus_wr && wb_adr_i == ttl_pkg::ADDR_CTRL && wb_sel_i[0])
		begin
			next_r.sense = wdat[ttl_pkg::CTRL_SENSE];
			next_r.range = wdat[ttl_pkg::CTRL_RANGE];
		end

		// Locate time is frozen while the difference is displayed
		if (!r.diff_mode)
		begin
			if (r.mem_load[1])
				next_r.locate = mem_rdata;
			else if (cmd[ttl_pkg::CMD_LOC_RST])
				next_r.locate = '0;
			else if (cmd[ttl_pkg::CMD_TO_LOC])
				next_r.locate = r.tape;
			else if (bus_wr && wb_adr_i == ttl_pkg::ADDR_LOC)
				next_r.locate = wdat[TW-1:0];
		end

		// Memory keys
		if (key_wr)
		begin
			if (r.diff_mode)
			begin
				if (key_code == ttl_pkg::KEY_RECALL)
					next_r.diff_mode = 1'b0;
			end
			else
			begin
				next_r.keymode = ttl_pkg::TTL_KEY_NONE;
				case (r.keymode)
					ttl_pkg::TTL_KEY_NONE:
					begin
						if (key_code == ttl_pkg::KEY_STORE)
							next_r.keymode = ttl_pkg::TTL_KEY_STORE;
						else if (key_code == ttl_pkg::KEY_RECALL)
							next_r.keymode = ttl_pkg::TTL_KEY_RECALL;
					end
					ttl_pkg::TTL_KEY_STORE:
					begin
						if (key_digit)
						begin
							next_r.mem_we = 1'b1;
							next_r.mem_addr = key_code - 4'h1;
						end
					end
					ttl_pkg::TTL_KEY_RECALL:
					begin
						if (key_code == ttl_pkg::KEY_ZERO)
							next_r.diff_mode = 1'b1;
						else if (key_digit)
						begin
							next_r.mem_addr = key_code - 4'h1;
							next_r.mem_load[0] = 1'b1;
						end
					end
					default:
						next_r.keymode = ttl_pkg::TTL_KEY_NONE;
				endcase
			end
		end

		// Transport sequencer
		if (cmd[ttl_pkg::CMD_STOP] || ext_rise[ttl_pkg::EXT_RUNOUT])
		begin
			next_r.state = ttl_pkg::TTL_IDLE;
			next_r.play_pend = 1'b0;
			next_r.rec = 1'b0;
		end
		else if (cmd[ttl_pkg::CMD_REW])
		begin
			next_r.state = ttl_pkg::TTL_REW;
			next_r.play_pend = 1'b0;
			next_r.rec = 1'b0;
		end
		else if (cmd[ttl_pkg::CMD_FWD])
		begin
			next_r.state = ttl_pkg::TTL_FWD;
			next_r.play_pend = 1'b0;
			next_r.rec = 1'b0;
		end
		else if (cmd[ttl_pkg::CMD_LOC])
		begin
			next_r.state = ttl_pkg::TTL_LFAST;
			next_r.play_pend = cmd[ttl_pkg::CMD_PLAY];
			next_r.rec = 1'b0;
		end
		else
		begin
			case (r.state)
				ttl_pkg::TTL_LFAST, ttl_pkg::TTL_LSLOW:
				begin
					if (cmd[ttl_pkg::CMD_PLAY])
						next_r.play_pend = 1'b1;
					if (near_tgt)
					begin
						next_r.play_pend = 1'b0;
						next_r.state = (r.play_pend || cmd[ttl_pkg::CMD_PLAY]) ?
							ttl_pkg::TTL_PLAY : ttl_pkg::TTL_IDLE;
					end
					else if (in_slow)
						next_r.state = ttl_pkg::TTL_LSLOW;
					else
						next_r.state = ttl_pkg::TTL_LFAST;
				end
				ttl_pkg::TTL_IDLE, ttl_pkg::TTL_PLAY:
				begin
					if (cmd[ttl_pkg::CMD_REC])
					begin
						next_r.state = ttl_pkg::TTL_PLAY;
						next_r.rec = 1'b1;
					end
					else if (cmd[ttl_pkg::CMD_PLAY])
						next_r.state = ttl_pkg::TTL_PLAY;
				end
				ttl_pkg::TTL_FWD, ttl_pkg::TTL_REW:
				begin
					if (cmd[ttl_pkg::CMD_PLAY])
						next_r.state = ttl_pkg::TTL_PLAY;
				end
				default:
					next_r.state = ttl_pkg::TTL_IDLE;
			endcase
		end

		// Registered transport outputs: {record, play, slow, rewind, forward}
		next_r.drv = '0;
		case (next_r.state)
			ttl_pkg::TTL_FWD:
				next_r.drv[0] = 1'b1;
			ttl_pkg::TTL_REW:
				next_r.drv[1] = 1'b1;
			ttl_pkg::TTL_LFAST, ttl_pkg::TTL_LSLOW:
			begin
				next_r.drv[0] = ~delta[TW];
				next_r.drv[1] = delta[TW];
				next_r.drv[2] = next_r.state == ttl_pkg::TTL_LSLOW;
			end
			ttl_pkg::TTL_PLAY:
			begin
				next_r.drv[3] = 1'b1;
				next_r.drv[4] = next_r.rec;
			end
			default:
				next_r.drv = '0;
		endcase

		// Read data, zero for unmapped addresses
		if (bus_req)
		begin
			next_r.dat = '0;
			case (wb_adr_i)
				ttl_pkg::ADDR_CTRL:
				begin
					next_r.dat[ttl_pkg::CTRL_SENSE] = r.sense;
					next_r.dat[ttl_pkg::CTRL_RANGE] = r.range;
				end
				ttl_pkg::ADDR_LOC:
					next_r.dat[TW-1:0] = r.diff_mode ? absd[TW-1:0] : r.locate;
				ttl_pkg::ADDR_TAPE:
					next_r.dat[TW-1:0] = r.tape;
				ttl_pkg::ADDR_STAT:
					next_r.dat[11:0] = {r.rec, r.play_pend, r.diff_mode, r.keymode, r.state};
				default:
					next_r.dat = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			r <= '0;
			r.state <= ttl_pkg::TTL_IDLE;
			r.keymode <= ttl_pkg::TTL_KEY_NONE;
			{r.range, r.sense} <= ttl_pkg::CTRL_RST;
		end
		else
			r <= next_r;
	end

	ttl_mem #(
		.DW    (TW),
		.DEPTH (ttl_pkg::MEM_DEPTH),
		.AW    (ttl_pkg::MEM_AW)
	) u_mem (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.we_i    (r.mem_we),
		.addr_i  (r.mem_addr),
		.wdata_i (r.locate),
		.rdata_o (mem_rdata)
	);

	assign wb_ack_o = r.ack;
	assign wb_dat_o = r.dat;
	assign drive_fwd_o = r.drv[0];
	assign drive_rew_o = r.drv[1];
	assign drive_slow_o = r.drv[2];
	assign play_o = r.drv[3];
	assign record_o = r.drv[4];

endmodule : ttl_ctrl

// ==== verif/ttl_ctrl_properties.sv ====
// Port checker of the tape time locate control
`timescale 1ns/1ps
module ttl_ctrl_properties (
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	input wire logic [7:0]                wb_adr_i,
	input wire logic [31:0]               wb_dat_i,
	input wire logic [31:0]               wb_dat_o,
	input wire logic                      wb_we_i,
	input wire logic [3:0]                wb_sel_i,
	input wire logic                      wb_stb_i,
	input wire logic                      wb_cyc_i,
	input wire logic                      wb_ack_o,
	input wire logic                      tape_pulse_i,
	input wire logic                      tape_dir_i,
	input wire logic [ttl_pkg::EXT_W-1:0] machine_cmd_i,
	input wire logic                      drive_fwd_o,
	input wire logic                      drive_rew_o,
	input wire logic                      drive_slow_o,
	input wire logic                      play_o,
	input wire logic                      record_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire cmd = take && wb_we_i && (wb_adr_i == ttl_pkg::ADDR_CMD) && wb_sel_i[0];
	property p_ack_resp; take |=> wb_ack_o ##1 !wb_ack_o; endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("ack not a one cycle answer");
	property p_stop; cmd && wb_dat_i[0] |=> ##1 !(drive_fwd_o || drive_rew_o || play_o); endproperty
	a_stop: assert property (p_stop) else $error("stop left motion");
	property p_rew; cmd && wb_dat_i[1:0] == 2'h2 |=> ##1 drive_rew_o && !drive_fwd_o; endproperty
	a_rew: assert property (p_rew) else $error("rewind not taken");
	property p_loc; cmd && wb_dat_i[9:0] == 10'h020 |=> ##1 drive_fwd_o ^ drive_rew_o; endproperty
	a_loc: assert property (p_loc) else $error("locate gave no fast drive");
	property p_excl; !(drive_fwd_o && drive_rew_o); endproperty
	a_excl: assert property (p_excl) else $error("both directions driven");
	property p_slow; drive_slow_o |-> drive_fwd_o || drive_rew_o; endproperty
	a_slow: assert property (p_slow) else $error("slow without locate drive");
	property p_hold; drive_fwd_o || drive_rew_o |-> !play_o && !record_o; endproperty
	a_hold: assert property (p_hold) else $error("play during fast motion");
	property p_rec; record_o |-> play_o; endproperty
	a_rec: assert property (p_rec) else $error("record without play");
	c_slow: cover property (drive_slow_o);
	c_play: cover property ($fell(drive_slow_o) ##1 play_o);
	c_rew: cover property (drive_rew_o && drive_slow_o);
endmodule : ttl_ctrl_properties

bind ttl_ctrl ttl_ctrl_properties i_props (
	.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i),
	.wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .tape_pulse_i(tape_pulse_i),
	.tape_dir_i(tape_dir_i), .machine_cmd_i(machine_cmd_i), .drive_fwd_o(drive_fwd_o),
	.drive_rew_o(drive_rew_o), .drive_slow_o(drive_slow_o), .play_o(play_o),
	.record_o(record_o)
);

// ==== verif/ttl_transport_model.sv ====
// Transport model: drive levels in, idler pulses and direction level out
`timescale 1ns/1ps
module ttl_transport_model #(
	parameter int PER = 4
) (
	input  wire logic clk_i,
	input  wire logic fwd_i,
	input  wire logic rew_i,
	input  wire logic slow_i,
	output logic      pulse_o,
	output logic      dir_o
);
	int cnt = 0;
	initial pulse_o = 1'b0;
	initial dir_o = 1'b1;
	// Idler stands still while neither forward nor rewind is driven
	always @(posedge clk_i)
	begin
		if (fwd_i || rew_i)
		begin
			dir_o <= !rew_i;
			cnt <= (cnt >= (slow_i ? 4 * PER : PER) - 1) ? 0 : cnt + 1;
			if (cnt == 0)
				pulse_o <= !pulse_o;
		end
		else
			cnt <= 0;
	end
endmodule : ttl_transport_model

// ==== verif/tb_ttl_ctrl.sv ====
// Self-checking bench of the tape time locate control
`timescale 1ns/1ps
module tb_ttl_ctrl;
	logic        clk_i;
	logic        rst_i;
	logic [7:0]  adr;
	logic [31:0] dw;
	logic [31:0] dr;
	logic [31:0] q;
	logic        we;
	logic [3:0]  sel;
	logic        stb;
	logic        cyc;
	logic        ack;
	logic        pulse;
	logic        dir;
	logic [4:0]  mc;
	logic        fwd;
	logic        rew;
	logic        slow;
	logic        play;
	logic        rec;
	logic        seen;
	int          fail_count = 0;
	int          tests_run = 0;
	int          v;
	int          tg [3] = '{60, 20, 90};
	int          ctl [4] = '{0, 1, 0, 2};
	int          mv [4] = '{4, 4, 2, 4};
	int          ex [4] = '{20, -20, -20, 10};
	// Rows: write flag, address, write data or expected read data
	logic [40:0] rows [33] = '{
		{1'b1, 8'h00, 32'hffffffff}, {1'b0, 8'h00, 32'h3}, {1'b1, 8'h00, 32'h0},
		{1'b1, 8'h0c, 32'hffffffff}, {1'b0, 8'h0c, 32'h3fff}, {1'b1, 8'h20, 32'hffffffff},
		{1'b0, 8'h20, 32'h0}, {1'b1, 8'h10, 32'h1234}, {1'b0, 8'h10, 32'h0},
		{1'b0, 8'h04, 32'h0}, {1'b1, 8'h0c, 32'h64}, {1'b1, 8'h08, 32'ha},
		{1'b1, 8'h08, 32'h1}, {1'b1, 8'h0c, 32'hc8}, {1'b1, 8'h08, 32'hb},
		{1'b1, 8'h08, 32'h0}, {1'b0, 8'h0c, 32'hc8}, {1'b1, 8'h08, 32'ha},
		{1'b1, 8'h08, 32'h1}, {1'b1, 8'h0c, 32'h5}, {1'b0, 8'h0c, 32'hc8},
		{1'b1, 8'h08, 32'hb}, {1'b0, 8'h0c, 32'hc8}, {1'b1, 8'h08, 32'hb},
		{1'b1, 8'h08, 32'h1}, {1'b0, 8'h04, 32'h0}, {1'b0, 8'h0c, 32'h64},
		{1'b1, 8'h04, 32'h80}, {1'b0, 8'h10, 32'h64}, {1'b1, 8'h04, 32'h200},
		{1'b0, 8'h0c, 32'h0}, {1'b1, 8'h04, 32'h100}, {1'b0, 8'h0c, 32'h64}};

	ttl_ctrl #(.SLOW_ZONE(4)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dw), .wb_dat_o(dr),
		.wb_we_i(we), .wb_sel_i(sel), .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_ack_o(ack),
		.tape_pulse_i(pulse), .tape_dir_i(dir), .machine_cmd_i(mc), .drive_fwd_o(fwd),
		.drive_rew_o(rew), .drive_slow_o(slow), .play_o(play), .record_o(rec));
	ttl_transport_model i_model (.clk_i(clk_i), .fwd_i(fwd), .rew_i(rew), .slow_i(slow),
		.pulse_o(pulse), .dir_o(dir));

	task automatic give_verdict();
		$display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_i);
		adr <= a;
		we <= w;
		dw <= d;
		sel <= 4'hf;
		cyc <= 1'b1;
		stb <= 1'b1;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic wait_halt();
		seen = 1'b0;
		@(negedge clk_i);
		while (fwd === 1'b1 || rew === 1'b1)
		begin
			seen = seen | slow;
			@(negedge clk_i);
		end
	endtask : wait_halt

	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = !clk_i;
	end

	initial
	begin
		#(40 * 40000);
		fail_count++;
		give_verdict();
	end

	initial
	begin
		{rst_i, adr, dw, we, sel, stb, cyc, mc} = {1'b1, 52'h0};
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(ttl_pkg::ADDR_STAT, 1'b0, 32'h0);
		chk(q, 32'h41);
		wb(ttl_pkg::ADDR_LOC, 1'b0, 32'h0);
		chk(q, 32'h0);
		$display("reset done");
		for (int i = 0; i < 33; i++)
		begin
			wb(rows[i][39:32], rows[i][40], rows[i][31:0]);
			if (!rows[i][40])
				chk(q, rows[i][31:0]);
		end
		wb(ttl_pkg::ADDR_CMD, 1'b1, 32'h10);
		@(negedge clk_i);
		chk({play, rec}, 2'h3);
		wb(ttl_pkg::ADDR_STAT, 1'b0, 32'h0);
		chk(q, 32'h842);
		wb(ttl_pkg::ADDR_CMD, 1'b1, 32'h1);
		@(negedge clk_i);
		chk({play, rec}, 2'h0);
		$display("register and memory rows done");
		for (int i = 0; i < 4; i++)
		begin
			wb(ttl_pkg::ADDR_CTRL, 1'b1, ctl[i]);
			wb(ttl_pkg::ADDR_CMD, 1'b1, 32'h40);
			wb(ttl_pkg::ADDR_CMD, 1'b1, mv[i]);
			repeat (160) @(posedge clk_i);
			wb(ttl_pkg::ADDR_CMD, 1'b1, 32'h1);
			repeat (8) @(posedge clk_i);
			wb(ttl_pkg::ADDR_TAPE, 1'b0, 32'h0);
			v = (q[13:0] > 14'h2000) ? int'(q[13:0]) - 16384 : int'(q[13:0]);
			chk(32'(v - ex[i] <= 2 && ex[i] - v <= 2), 32'h1);
		end
		$display("counting done");
		wb(ttl_pkg::ADDR_CTRL, 1'b1, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			wb(ttl_pkg::ADDR_LOC, 1'b1, tg[i]);
			wb(ttl_pkg::ADDR_CMD, 1'b1, 32'h20);
			@(negedge clk_i);
			chk({fwd, rew}, (i == 1) ? 2'h1 : 2'h2);
			if (i == 2)
				wb(ttl_pkg::ADDR_CMD, 1'b1, 32'h18);
			chk({play, rec}, 2'h0);
			wait_halt();
			chk({play, rec, seen}, (i == 2) ? 3'h5 : 3'h1);
			repeat (8) @(posedge clk_i);
			wb(ttl_pkg::ADDR_TAPE, 1'b0, 32'h0);
			v = int'(q[13:0]) - tg[i];
			chk(32'(v <= 1 && v >= -1), 32'h1);
			wb(ttl_pkg::ADDR_STAT, 1'b0, 32'h0);
			chk(q, (i == 2) ? 32'h42 : 32'h41);
		end
		$display("locate done");
		for (int b = 0; b < 3; b++)
		begin
			wb(ttl_pkg::ADDR_LOC, 1'b1, 32'h3000);
			wb(ttl_pkg::ADDR_CMD, 1'b1, 32'h20);
			repeat (20) @(posedge clk_i);
			if (b == 0)
				wb(ttl_pkg::ADDR_CMD, 1'b1, 32'h4);
			else
				mc <= (b == 1) ? 5'h01 : 5'h10;
			repeat (8) @(posedge clk_i);
			mc <= 5'h00;
			@(negedge clk_i);
			chk({fwd, rew, slow}, (b == 0) ? 3'h4 : 3'h0);
		end
		$display("cancel done");
		wb(ttl_pkg::ADDR_CMD, 1'b1, 32'h20);
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk({fwd, rew, slow, play, rec}, 5'h0);
		wb(ttl_pkg::ADDR_STAT, 1'b0, 32'h0);
		chk(q, 32'h41);
		wb(ttl_pkg::ADDR_TAPE, 1'b0, 32'h0);
		chk(q, 32'h0);
		wb(ttl_pkg::ADDR_LOC, 1'b0, 32'h0);
		chk(q, 32'h0);
		$display("mid-run reset done");
		give_verdict();
	end
endmodule : tb_ttl_ctrl
